// ==== src/isc_pkg.sv ====
// shared constants and types for the instruction sequence control block
package isc_pkg;
  // time slots of one machine cycle, slot 1.1 = 0 up to slot 6.4 = 23
  localparam logic [4:0] T11 = 5'h00, T12 = 5'h01, T13 = 5'h02, T14 = 5'h03;
  localparam logic [4:0] T21 = 5'h04, T22 = 5'h05, T23 = 5'h06;
  localparam logic [4:0] T32 = 5'h09, T33 = 5'h0A;
  localparam logic [4:0] T41 = 5'h0C, T42 = 5'h0D, T43 = 5'h0E, T44 = 5'h0F;
  localparam logic [4:0] T51 = 5'h10, T52 = 5'h11, T53 = 5'h12, T54 = 5'h13;
  localparam logic [4:0] T61 = 5'h14, T62 = 5'h15, T63 = 5'h16, T64 = 5'h17;
  localparam logic [4:0] SLOT_RST = 5'h00;
  // function codes (octal 17..30)
  localparam logic [4:0] F_SKIP_ZERO = 5'h0F;  // skip_on_zero_count
  localparam logic [4:0] F_EXCHANGE  = 5'h10;  // exchange_acc_memory
  localparam logic [4:0] F_ADD_CONST = 5'h11;
  localparam logic [4:0] F_INC_MEM   = 5'h12;  // increment_memory
  localparam logic [4:0] F_COND_INC  = 5'h13;  // conditional_increment
  localparam logic [4:0] F_FLAG_SET  = 5'h14;  // flag_set_instruction
  localparam logic [4:0] F_FLAG_CLR  = 5'h15;  // flag_clear_instruction
  localparam logic [4:0] F_IDX_STORE = 5'h16;  // index_store, count_store
  localparam logic [4:0] F_IDX_LOAD  = 5'h17;  // index_load, count_load
  localparam logic [4:0] F_CLR_ADD   = 5'h18;  // clear_and_add
  localparam logic [4:0] MOD_BASE    = 5'h1F;  // modifier 37 octal
  localparam logic [13:0] FIXED_LOC  = 14'h0020;  // location 40 octal
  // gray coded along I, M, R, W, next instruction
  typedef enum logic [2:0] {
    SEQ_NONE = 3'h0,
    SEQ_I    = 3'h1,
    SEQ_M    = 3'h3,
    SEQ_R    = 3'h2,
    SEQ_W    = 3'h6,
    SEQ_NI   = 3'h7
  } isc_seq_type;
  localparam isc_seq_type SEQ_RST = SEQ_NI;
  // request to the core memory cycle
  typedef struct packed {
    logic        initiate;
    logic        strobe;
    logic        write;
    logic [13:0] addr;
    logic [23:0] wdata;
  } isc_mem_req_type;
endpackage

// ==== src/isc_core.sv ====
// instruction sequence control: fetch, modify, read and write sequencing
`timescale 1ns/1ps
// Operation
// - fetch: pc to address, start memory, pc+1 via adder, strobe, sum back to pc
// - end of fetch: clear inputs, split fetched word into X, modifier, function
// - modifier 37 on any op but add constant: low X to D, base index to X, word bits 9-13 to modifier
// - ordinary instructions go to read when modifier zero, else modify first
// - modify: address by modifier, adder into data, add index to form address
// - word count field is bits 14-20 for modifier zero, else bits 14-21
// - skip on zero count clears flag, sets it on zero count and bumps pc
// - exchange swaps accumulator and memory word, then writes old accumulator
// - timing chain steps happen only while the arithmetic timing chain runs
// - add constant: memory word plus modifier value, sum written back
// - increment: memory word plus one, sum written back to same address
// - conditional increment proceeds only when accumulator bits 23 and 24 differ
// - flag set sets flag each sequence, write addresses location 40
// - flag clear clears flag each sequence, read addresses location 40
// - index load with zero modifier clears then loads zeroth count from memory
// - index load ends on zero modifier, else writes at modifier address
// - index load with modifier 37 also reloads base index from adder
// - clear and add moves memory word through D into cleared accumulator
module isc_core (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire logic [23:0]              mem_rdata,
  input  wire logic                     atc_run,
  input  wire logic                     op_state_set,
  output isc_pkg::isc_mem_req_type      mem_req,
  output logic                          atc_start,
  output logic                          next_instruction_sequence,
  output isc_pkg::isc_seq_type          seq,
  output logic [4:0]                    slot,
  output logic [13:0]                   pc,
  output logic [24:0]                   acc,
  output logic [13:0]                   base_index,
  output logic [4:0]                    func,
  output logic [4:0]                    modifier,
  output logic [4:0]                    zeroth_count_reg,
  output logic                          op_state_bit,
  output logic                          bypass_next_flag,
  output logic                          fixed_location_flag
);
  import isc_pkg::*;

  logic [13:0] s;
  logic [23:0] x;
  logic [23:0] d;
  logic [23:0] z;
  logic [4:0]  fmod;
  logic [23:0] adder;
  isc_seq_type succ;
  logic        is_i, is_m, is_r, is_w;
  logic        idx_op, c37, cidx, chain_op, wc_zero, keep_sum;

  function automatic logic at(input logic [4:0] cur, input logic [4:0] want);
    return cur == want;
  endfunction

  // word count test: narrower field when no modifier
  function automatic logic count_zero(input logic [23:0] w, input logic [4:0] mod);
    return (mod == 5'h00) ? (w[20:14] == 7'h00) : (w[21:14] == 8'h00);
  endfunction

  assign adder    = x + d;
  assign is_i     = seq == SEQ_I;
  assign is_m     = seq == SEQ_M;
  assign is_r     = seq == SEQ_R;
  assign is_w     = seq == SEQ_W;
  assign idx_op   = func == F_SKIP_ZERO || func == F_IDX_STORE || func == F_IDX_LOAD;
  assign c37      = fmod == MOD_BASE && func != F_ADD_CONST;
  assign cidx     = idx_op && fmod == 5'h00;
  assign chain_op = func == F_EXCHANGE || func == F_CLR_ADD;
  // these reads leave X and D alone: their write sequence addresses by the held sum
  assign keep_sum = func == F_FLAG_CLR || func == F_IDX_STORE;
  assign wc_zero  = count_zero(z, modifier);

  ////////////////////////////////////////////////////////////////////////////
  // slot counter and sequence flags

  // one slot per clock; a full machine cycle is 24 clocks
  always_ff @(posedge clk) begin
    if (srst || at(slot, T64)) begin
      slot <= SLOT_RST;
    end else begin
      slot <= slot + 5'h01;
    end
  end

  // successor chosen at 5.4 so the flag may be empty for one slot
  always_ff @(posedge clk) begin
    if (srst) begin
      seq  <= SEQ_RST;
      succ <= SEQ_I;
    end else if (at(slot, T54)) begin
      seq <= SEQ_NONE;
      unique case (seq)
        SEQ_I: begin
          if (func == F_COND_INC && acc[23] == acc[24]) begin
            succ <= SEQ_NI;
          end else if (func == F_ADD_CONST) begin
            succ <= SEQ_R;
          end else if (idx_op) begin
            succ <= (c37 || fmod == 5'h00) ? SEQ_R : SEQ_M;
          end else if (func >= F_EXCHANGE && func <= F_CLR_ADD) begin
            succ <= (modifier == 5'h00) ? SEQ_R : SEQ_M;
          end else begin
            succ <= SEQ_NI;
          end
        end
        SEQ_M:  succ <= SEQ_R;
        SEQ_R: begin
          if (func == F_SKIP_ZERO || func == F_CLR_ADD) begin
            succ <= SEQ_NI;
          end else if (func == F_IDX_LOAD) begin
            succ <= (modifier == 5'h00) ? SEQ_NI : SEQ_W;
          end else begin
            succ <= SEQ_W;
          end
        end
        SEQ_W:    succ <= SEQ_NI;
        SEQ_NI:   succ <= SEQ_I;
        SEQ_NONE: succ <= succ;
        default:  succ <= SEQ_NI;
      endcase
    end else if (at(slot, T61)) begin
      seq <= succ;
    end
  end

  // the next instruction sequence itself lies outside; flag its start
  assign next_instruction_sequence = at(slot, T61) && succ == SEQ_NI;
  assign atc_start = is_r && chain_op && at(slot, T32);

  ////////////////////////////////////////////////////////////////////////////
  // memory cycle requests

  assign mem_req.initiate = at(slot, T12) && seq != SEQ_NONE && seq != SEQ_NI;
  assign mem_req.strobe   = at(slot, T22) && (is_i || is_m || is_r);
  assign mem_req.write    = is_w;
  assign mem_req.addr     = s;
  assign mem_req.wdata    = z;

  // address register
  always_ff @(posedge clk) begin
    if (srst) begin
      s <= 14'h0000;
    end else if (at(slot, T64)) begin
      if ((is_w && func == F_FLAG_SET) || (is_r && func == F_FLAG_CLR)) begin
        s <= FIXED_LOC;
      end else if (!(is_w && func >= F_EXCHANGE && func <= F_COND_INC)) begin
        s <= 14'h0000;
      end
    end else if (at(slot, T11)) begin
      if (is_i) begin
        s <= pc;
      end else if (is_m || (is_r && func == F_IDX_STORE)) begin
        s <= {9'h000, modifier};
      end else if (is_w && func == F_IDX_LOAD) begin
        s <= {9'h000, modifier};
      end else if ((is_r && func != F_FLAG_CLR)
                   || (is_w && (func == F_FLAG_CLR || func == F_IDX_STORE))) begin
        s <= adder[13:0];
      end
    end
  end

  // memory data register
  always_ff @(posedge clk) begin
    if (srst) begin
      z <= 24'h000000;
    end else if (at(slot, T64)) begin
      if (!is_w || (func >= F_EXCHANGE && func <= F_COND_INC)
          || (func == F_IDX_STORE && modifier == 5'h00)) begin
        z <= 24'h000000;
      end
    end else if (at(slot, T11)) begin
      if (is_m || (is_w && func >= F_ADD_CONST && func <= F_COND_INC)) begin
        z <= adder;
      end else if (is_w && func == F_IDX_STORE && modifier == 5'h00) begin
        z[4:0] <= zeroth_count_reg;
      end
    end else if (at(slot, T14) && is_m) begin
      z <= 24'h000000;
    end else if (at(slot, T21) && is_w && func == F_EXCHANGE) begin
      z <= x;
    end else if (mem_req.strobe) begin
      z <= mem_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // adder inputs

  always_ff @(posedge clk) begin
    if (srst) begin
      x <= 24'h000000;
    end else if (at(slot, T12) && (is_i || is_m)) begin
      x <= 24'h000000;
    end else if (at(slot, T13) && is_i) begin
      x <= {10'h000, pc};
    end else if (at(slot, T13) && is_m) begin
      x <= {10'h000, z[13:0]};
    end else if (at(slot, T32) && (is_i || is_m || (is_r && !keep_sum))) begin
      x <= 24'h000000;
    end else if (at(slot, T33) && (is_i || is_m || (is_r && func == F_IDX_LOAD))) begin
      x <= {10'h000, z[13:0]};
    end else if (at(slot, T33) && is_r && !keep_sum) begin
      x <= z;
    end else if (at(slot, T42) && ((is_i && (c37 || cidx)) || (is_r && chain_op && atc_run))) begin
      x <= 24'h000000;
    end else if (at(slot, T43) && is_i && c37) begin
      x <= {10'h000, base_index};
    end else if (at(slot, T43) && is_r && chain_op && atc_run) begin
      x <= acc[23:0];
    end else if (at(slot, T52) && is_r && func == F_SKIP_ZERO && wc_zero) begin
      x <= 24'h000000;
    end else if (at(slot, T53) && is_r && func == F_SKIP_ZERO && wc_zero) begin
      x <= {10'h000, pc};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      d <= 24'h000000;
    end else if (at(slot, T12) && (is_i || is_m)) begin
      d <= 24'h000000;
    end else if (at(slot, T13) && is_i) begin
      d <= 24'h000001;
    end else if (at(slot, T21) && is_m) begin
      d <= x;
    end else if (at(slot, T32) && (is_i || (is_r && func != F_SKIP_ZERO && !keep_sum))) begin
      d <= 24'h000000;
    end else if (at(slot, T33) && is_r && func == F_ADD_CONST) begin
      d <= {19'h00000, modifier};
    end else if (at(slot, T33) && is_r && (func == F_INC_MEM || func == F_COND_INC)) begin
      d <= 24'h000001;
    end else if (at(slot, T41) && is_i && (c37 || cidx)) begin
      d <= {15'h0000, x[8:0]};
    end else if (at(slot, T41) && is_r && chain_op && atc_run) begin
      d <= (func == F_EXCHANGE) ? ~x : x;
    end else if (at(slot, T52) && is_r && func == F_SKIP_ZERO && wc_zero) begin
      d <= 24'h000000;
    end else if (at(slot, T53) && is_r && func == F_SKIP_ZERO && wc_zero) begin
      d <= 24'h000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program counter, function and modifier

  // skip is applied during the following next instruction sequence
  always_ff @(posedge clk) begin
    if (srst) begin
      pc <= 14'h0000;
    end else if ((at(slot, T22) && is_i)
                 || (at(slot, T62) && seq == SEQ_NI && func == F_SKIP_ZERO && bypass_next_flag)) begin
      pc <= 14'h0000;
    end else if ((at(slot, T23) && is_i)
                 || (at(slot, T63) && seq == SEQ_NI && func == F_SKIP_ZERO && bypass_next_flag)) begin
      pc <= adder[13:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      func     <= 5'h00;
      modifier <= 5'h00;
      fmod     <= 5'h00;
    end else if (at(slot, T32) && is_i) begin
      func     <= 5'h00;
      modifier <= 5'h00;
    end else if (at(slot, T33) && is_i) begin
      modifier <= z[18:14];
      func     <= z[23:19];
      fmod     <= z[18:14];
    end else if (at(slot, T42) && is_i && (c37 || cidx)) begin
      modifier <= 5'h00;
    end else if (at(slot, T43) && is_i && (c37 || cidx)) begin
      modifier <= z[13:9];
    end
  end

  // op state bit: the external set wins over the fetch clear
  always_ff @(posedge clk) begin
    if (srst) begin
      op_state_bit <= 1'b0;
    end else if (op_state_set) begin
      op_state_bit <= 1'b1;
    end else if (at(slot, T33) && is_i) begin
      op_state_bit <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator, base index, zeroth count, flags

  always_ff @(posedge clk) begin
    if (srst) begin
      acc <= 25'h0000000;
    end else if (at(slot, T44) && is_r && chain_op && atc_run) begin
      acc <= 25'h0000000;
    end else if (at(slot, T51) && is_r && chain_op && atc_run) begin
      acc <= (func == F_EXCHANGE) ? {~d[23], ~d} : {d[23], d};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      base_index <= 14'h0000;
    end else if (is_w && func == F_IDX_LOAD && modifier == MOD_BASE) begin
      if (at(slot, T62)) begin
        base_index <= 14'h0000;
      end else if (at(slot, T63)) begin
        base_index <= adder[13:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      zeroth_count_reg <= 5'h00;
    end else if (is_r && func == F_IDX_LOAD && modifier == 5'h00) begin
      if (at(slot, T43)) begin
        zeroth_count_reg <= 5'h00;
      end else if (at(slot, T44)) begin
        zeroth_count_reg <= z[4:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bypass_next_flag <= 1'b0;
    end else if (at(slot, T44) && is_r && func == F_SKIP_ZERO && wc_zero) begin
      bypass_next_flag <= 1'b1;
    end else if (at(slot, T64) && is_r && func == F_SKIP_ZERO) begin
      bypass_next_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fixed_location_flag <= 1'b0;
    end else if (at(slot, T53) && (is_i || is_m || is_r || is_w)) begin
      if (func == F_FLAG_SET) begin
        fixed_location_flag <= 1'b1;
      end else if (func == F_FLAG_CLR) begin
        fixed_location_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_fetch_addr;
    @(posedge clk) disable iff (srst)
    (is_i && at(slot, T11)) |=> (mem_req.addr == $past(pc)) && mem_req.initiate;
  endproperty
  a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address wrong");

  property p_fetch_split;
    @(posedge clk) disable iff (srst)
    (is_i && at(slot, T33)) |=> func == $past(z[23:19]) && fmod == $past(z[18:14]);
  endproperty
  a_fetch_split: assert property (p_fetch_split) else $error("fetch split wrong");

  property p_base_mod;
    @(posedge clk) disable iff (srst)
    (is_i && at(slot, T41) && c37 && !idx_op) |-> ##3 x == {10'h000, base_index};
  endproperty
  a_base_mod: assert property (p_base_mod) else $error("base index not loaded");

  property p_read_next;
    @(posedge clk) disable iff (srst)
    (is_i && at(slot, T54) && func == F_CLR_ADD && modifier == 5'h00) |-> ##2 seq == SEQ_R;
  endproperty
  a_read_next: assert property (p_read_next) else $error("read sequence not entered");

  property p_skip_set;
    @(posedge clk) disable iff (srst)
    (is_r && at(slot, T44) && func == F_SKIP_ZERO && wc_zero) |=> bypass_next_flag;
  endproperty
  a_skip_set: assert property (p_skip_set) else $error("skip flag not set");

  property p_chain_gate;
    @(posedge clk) disable iff (srst)
    (is_r && chain_op && at(slot, T44) && !atc_run) |=> $stable(acc);
  endproperty
  a_chain_gate: assert property (p_chain_gate) else $error("accumulator moved");

  property p_cond_inc;
    @(posedge clk) disable iff (srst)
    (is_i && at(slot, T54) && func == F_COND_INC && acc[23] == acc[24]) |-> ##2 seq == SEQ_NI;
  endproperty
  a_cond_inc: assert property (p_cond_inc) else $error("increment not skipped");

  property p_fixed_addr;
    @(posedge clk) disable iff (srst)
    (is_w && func == F_FLAG_SET && at(slot, T12)) |-> mem_req.addr == FIXED_LOC;
  endproperty
  a_fixed_addr: assert property (p_fixed_addr) else $error("fixed location missed");

  property p_count_load;
    @(posedge clk) disable iff (srst)
    (is_r && at(slot, T44) && func == F_IDX_LOAD && modifier == 5'h00)
      |=> zeroth_count_reg == $past(z[4:0]);
  endproperty
  a_count_load: assert property (p_count_load) else $error("count not loaded");

  property p_seq_gap;
    @(posedge clk) disable iff (srst)
    at(slot, T54) |=> seq == SEQ_NONE ##1 seq != SEQ_NONE;
  endproperty
  a_seq_gap: assert property (p_seq_gap) else $error("sequence handover wrong");

  c_skip: cover property (@(posedge clk) disable iff (srst)
    is_r && func == F_SKIP_ZERO && at(slot, T44) && wc_zero);
  c_exch: cover property (@(posedge clk) disable iff (srst)
    is_w && func == F_EXCHANGE && at(slot, T21));
  c_base: cover property (@(posedge clk) disable iff (srst)
    is_w && func == F_IDX_LOAD && modifier == MOD_BASE && at(slot, T63));
  c_modify: cover property (@(posedge clk) disable iff (srst) is_m && at(slot, T22));
endmodule

// ==== tb/isc_mem_model.sv ====
// behavioural core memory and arithmetic timing chain facing the sequence control block
`timescale 1ns/1ps
module isc_mem_model (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire isc_pkg::isc_mem_req_type mem_req,
  input  wire logic                     atc_start,
  input  wire logic                     atc_slow,
  output logic [23:0]                   mem_rdata,
  output logic                          atc_run,
  output logic [13:0]                   last_waddr
);
  import isc_pkg::*;
  logic [23:0] mem [0:16383];
  logic [23:0] last_word;
  logic        wr_arm;
  logic [13:0] waddr;
  logic [3:0]  run_cnt;
  //////////////////////////////////////////////////////////////////////////////
  // zero latency read; off strobe the line shows the inverse of the last word, never a stale copy
  assign mem_rdata = mem_req.strobe ? mem[mem_req.addr] : ~last_word;
  assign atc_run   = (run_cnt != 4'h0);
  // write cycle: the last data offered before the write level drops is the one kept
  always @(posedge clk) begin
    if (srst) begin
      wr_arm     <= 1'b0;
      last_waddr <= 14'h0000;
      last_word  <= 24'h000000;
    end else begin
      if (mem_req.strobe) last_word <= mem[mem_req.addr];
      if (mem_req.initiate && mem_req.write) begin
        wr_arm     <= 1'b1;
        waddr      <= mem_req.addr;
        last_waddr <= mem_req.addr;
      end else if (!mem_req.write) wr_arm <= 1'b0;
      else if (wr_arm) mem[waddr] <= mem_req.wdata;
    end
  end
  // timing chain runs eight clocks after a start; slow mode holds it off entirely
  always @(posedge clk) begin
    if (srst) run_cnt <= 4'h0;
    else if (atc_start && !atc_slow) run_cnt <= 4'h8;
    else if (run_cnt != 4'h0) run_cnt <= run_cnt - 4'h1;
  end
endmodule

// ==== tb/instruction_sequence_control_tb.sv ====
// self-checking bench for the instruction sequence control block
`timescale 1ns/1ps
module instruction_sequence_control_tb;
  import isc_pkg::*;
  logic            clk, srst, op_state_set, atc_slow, atc_start, atc_run;
  logic            next_instruction_sequence, op_state_bit, bypass_next_flag;
  logic            fixed_location_flag;
  logic [23:0]     mem_rdata;
  isc_mem_req_type mem_req;
  isc_seq_type     seq;
  logic [4:0]      slot, func, modifier, zeroth_count_reg, zc_e;
  logic [13:0]     pc, base_index, last_waddr, pc_e, base_e;
  logic [24:0]     acc, acc_e;
  int              failures, n_checks;
  //////////////////////////////////////////////////////////////////////////////
  isc_core dut (.clk(clk), .srst(srst), .mem_rdata(mem_rdata), .atc_run(atc_run),
    .op_state_set(op_state_set), .mem_req(mem_req), .atc_start(atc_start),
    .next_instruction_sequence(next_instruction_sequence), .seq(seq), .slot(slot), .pc(pc),
    .acc(acc), .base_index(base_index), .func(func), .modifier(modifier),
    .zeroth_count_reg(zeroth_count_reg), .op_state_bit(op_state_bit),
    .bypass_next_flag(bypass_next_flag), .fixed_location_flag(fixed_location_flag));
  isc_mem_model u_mem (.clk(clk), .srst(srst), .mem_req(mem_req), .atc_start(atc_start),
    .atc_slow(atc_slow), .mem_rdata(mem_rdata), .atc_run(atc_run), .last_waddr(last_waddr));
  //////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [24:0] sext(input logic [23:0] w);
    return {w[23], w};
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // plant one instruction at the expected counter and run it to the next instruction pulse
  task automatic exec(input logic [4:0] f, input logic [4:0] m, input logic [13:0] a,
                      input logic skip, output logic sm, output logic sw);
    logic       si;
    int         n;
    logic [4:0] me;
    sm = 1'b0;
    sw = 1'b0;
    si = 1'b0;
    n = 0;
    u_mem.mem[pc_e] = {f, m, a};
    while (n < 300 && !(si && next_instruction_sequence === 1'b1)) begin
      @(posedge clk);
      #1;
      n++;
      si |= (seq === SEQ_I);
      sm |= (seq === SEQ_M);
      sw |= (seq === SEQ_W);
    end
    chk("instruction end", n < 300, 1);
    chk("slot at next instruction", slot, T61);
    repeat (6) @(posedge clk);
    #1;
    pc_e = pc_e + 14'h0001 + 14'(skip);
    chk("pc", pc, pc_e);
    chk("function", func, f);
    // index ops with field 0 or 37, and any non constant op with 37, take bits 9-13
    me = ((m == 5'h00 && (f == F_SKIP_ZERO || f == F_IDX_STORE || f == F_IDX_LOAD))
          || (m == MOD_BASE && f != F_ADD_CONST)) ? a[13:9] : m;
    chk("modifier", modifier, me);
    chk("op state cleared", op_state_bit, 0);
    op_state_set = 1'b1;
    @(posedge clk);
    #1 op_state_set = 1'b0;
    chk("op state set", op_state_bit, 1);
  endtask
  // one instruction of kind k with random operands; the bench mirrors its effect
  task automatic do_op(input int k);
    logic [13:0] a, idx, eff;
    logic [23:0] d;
    logic [4:0]  m;
    logic        sm, sw;
    int          pat;
    a = 14'h0100 + 14'($urandom_range(0, 255));
    d = $urandom;
    m = 5'h00;
    eff = a;
    pat = $urandom_range(0, 2);
    case (k)
      0: begin
        atc_slow = (pat == 1);
        u_mem.mem[a] = d;
        exec(F_CLR_ADD, m, a, 1'b0, sm, sw);
        if (!atc_slow) acc_e = sext(d);
        chk("clear add acc", acc, acc_e);
        atc_slow = 1'b0;
      end
      1: begin
        u_mem.mem[a] = d;
        exec(F_EXCHANGE, m, a, 1'b0, sm, sw);
        chk("exchange store", u_mem.mem[a], acc_e[23:0]);
        acc_e = sext(d);
        chk("exchange acc", acc, acc_e);
      end
      2: begin
        m = 5'($urandom_range(0, 31));
        d = d & 24'h3FFFFF;
        u_mem.mem[a] = d;
        exec(F_ADD_CONST, m, a, 1'b0, sm, sw);
        chk("constant sum", u_mem.mem[a], d + 24'(m));
      end
      3: begin
        if (pat == 1) begin
          m = 5'h1D;
          idx = 14'($urandom_range(0, 63));
          u_mem.mem[29] = {10'h000, idx};
          eff = a + idx;
        end else if (pat == 2) begin
          m = MOD_BASE;
          eff = base_e + a;
        end
        d = d & 24'h3FFFFF;
        u_mem.mem[eff] = d;
        exec(F_INC_MEM, m, a, 1'b0, sm, sw);
        chk("modify taken", sm, m == 5'h1D);
        chk("increment", u_mem.mem[eff], d + 24'h1);
      end
      4: begin
        u_mem.mem[a] = d;
        exec(F_COND_INC, m, a, 1'b0, sm, sw);
        chk("cond inc untouched", u_mem.mem[a], d);
        chk("cond inc ended", {sm, sw}, 0);
      end
      5: begin
        exec(F_FLAG_SET, m, a, 1'b0, sm, sw);
        chk("flag set", fixed_location_flag, 1);
        chk("fixed write address", last_waddr, FIXED_LOC);
      end
      6: begin
        exec(F_FLAG_CLR, m, a, 1'b0, sm, sw);
        chk("flag clear", fixed_location_flag, 0);
        chk("clear write address", last_waddr, a);
      end
      7: begin
        u_mem.mem[a] = d;
        exec(F_IDX_LOAD, m, a, 1'b0, sm, sw);
        zc_e = d[4:0];
        chk("count load", zeroth_count_reg, zc_e);
        chk("load ends at read", sw, 0);
      end
      8: begin
        u_mem.mem[a] = ~d;
        exec(F_IDX_STORE, m, a, 1'b0, sm, sw);
        chk("count store", u_mem.mem[a], {19'h00000, zc_e});
      end
      9: begin
        d = (d & ~24'h3FC000) | (pat == 0 ? 24'h200000 : (pat == 1 ? 24'h100000 : 24'h0));
        u_mem.mem[a] = d;
        exec(F_SKIP_ZERO, m, a, pat != 1, sm, sw);
        chk("skip flag", bypass_next_flag, pat != 1);
      end
      10: begin
        // index 37 named in address bits 9-13: word goes to location 37 and to base
        d[13:0] = 14'h0400 | 14'(d[7:0]);
        u_mem.mem[a] = d;
        exec(F_IDX_LOAD, m, a | 14'h3E00, 1'b0, sm, sw);
        base_e = d[13:0];
        chk("base load", base_index, base_e);
        chk("index word", u_mem.mem[31], d);
        chk("index write address", last_waddr, 14'h001F);
        chk("load goes on to write", sw, 1);
      end
      default: ;
    endcase
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // reset, then every instruction kind once and a random tail
  initial begin
    void'($urandom(23307));
    srst = 1'b1;
    op_state_set = 1'b0;
    atc_slow = 1'b0;
    failures = 0;
    n_checks = 0;
    pc_e = 14'h0000;
    acc_e = 25'h0000000;
    zc_e = 5'h00;
    base_e = 14'h0000;
    repeat (4) @(posedge clk);
    #1 srst = 1'b0;
    for (int i = 0; i < 16; i++) begin
      do_op(i < 11 ? i : $urandom_range(0, 10));
    end
    give_verdict();
  end
  // watchdog well beyond sixteen instructions of five machine cycles each
  initial begin
    #500000;
    failures++;
    give_verdict();
  end
endmodule
